// file: olr_defines.vh
// What this block does
// - Write to command 3Bh updates OTG output voltage limit.
// - Voltage field is bits 13:2, 8 mV per LSB, MSB 16384 mV.
// - Applied OTG voltage setting is clamped between 3 V and 24 V.
// - Voltage writes below 3 V or above 24 V are discarded.
// - Voltage resets to 09C4h, current resets to 3C00h.
// - Write to command 3Ch updates OTG output current limit.
// - Current field is bits 14:8, 50 mA per LSB, MSB 3200 mA.
// - Writes with reserved upper bits set are invalid and rejected.
// - Reserved low bits are ignored on write and read as zero.
`ifndef OLR_DEFINES_VH
`define OLR_DEFINES_VH
`define OLR_CMD_VOLT 8'h3B
`define OLR_CMD_CURR 8'h3C
`define OLR_VOLT_RESET 16'h09C4
`define OLR_CURR_RESET 16'h3C00
`define OLR_VOLT_MSB 13
`define OLR_VOLT_LSB 2
`define OLR_VOLT_RSVD_HI 16'hC000
`define OLR_CURR_MSB 14
`define OLR_CURR_LSB 8
`define OLR_CURR_RSVD_HI 16'h8000
`define OLR_VOLT_STEP_MV 8
`define OLR_VOLT_MIN_MV 3000
`define OLR_VOLT_MAX_MV 24000
`define OLR_VOLT_MIN_CODE 12'h0177
`define OLR_VOLT_MAX_CODE 12'h0BB8
`define OLR_VOLT_RESET_CODE 12'h0271
`define OLR_CURR_RESET_CODE 7'h3C
`define OLR_ZERO16 16'h0000
`endif

// file: olr_host.sv
`timescale 1ns/1ps
module olr_host (
	input wire clk,
	output reg wr_en,
	output reg rd_en,
	output reg [7:0] cmd,
	output reg [15:0] wr_data
);
initial
begin
	wr_en = 1'h0;
	rd_en = 1'h0;
	cmd = 8'h00;
	wr_data = 16'h0000;
end
// Reserved high bits are set only when a test means to be refused
task wr(input [7:0] c, input [15:0] d);
	begin
		@(posedge clk) {wr_en, cmd, wr_data} <= {1'h1, c, d};
		@(posedge clk) wr_en <= 1'h0;
	end
endtask
task rd(input [7:0] c);
	begin
		@(posedge clk) {rd_en, cmd} <= {1'h1, c};
		@(posedge clk) rd_en <= 1'h0;
	end
endtask
endmodule // olr_host

// file: olr_props.sv
`timescale 1ns/1ps
module olr_props (
	input wire clk,
	input wire rst,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] cmd,
	input wire [15:0] wr_data,
	input wire [15:0] rd_data,
	input wire rd_valid,
	input wire wr_reject,
	input wire [11:0] otg_voltage_code,
	input wire [6:0] otg_current_code
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	wire vw = wr_en && (cmd == 8'h3B);
	wire cw = wr_en && (cmd == 8'h3C);
	rd_pulse_a: assert property (rd_en |=> rd_valid) else $error("no read answer");
	volt_rsvd_a: assert property (vw && wr_data[15:14] != 2'h0 |=> wr_reject) else $error("bad volt kept");
	curr_rsvd_a: assert property (cw && wr_data[15] |=> wr_reject) else $error("bad curr kept");
	volt_low_a: assert property (vw && wr_data[13:2] < 12'h0177 |=> wr_reject) else $error("low kept");
	volt_high_a: assert property (vw && wr_data[13:2] > 12'h0BB8 |=> wr_reject) else $error("high kept");
	volt_apply_a: assert property (vw && wr_data[15:14] == 2'h0 && wr_data[13:2] inside {[375:3000]}
		|=> ##1 otg_voltage_code == $past(wr_data[13:2], 2)) else $error("volt not applied");
	curr_apply_a: assert property (cw && !wr_data[15]
		|=> ##1 otg_current_code == $past(wr_data[14:8], 2)) else $error("curr not applied");
	volt_clamp_a: assert property (otg_voltage_code inside {[375:3000]}) else $error("volt out of clamp");
	cover property (wr_reject);
	cover property (rd_valid);
	cover property (cw);
endmodule // olr_props
bind olr_regs olr_props u_props (
	.clk(clk),
	.rst(rst),
	.wr_en(wr_en),
	.rd_en(rd_en),
	.cmd(cmd),
	.wr_data(wr_data),
	.rd_data(rd_data),
	.rd_valid(rd_valid),
	.wr_reject(wr_reject),
	.otg_voltage_code(otg_voltage_code),
	.otg_current_code(otg_current_code)
);

// file: olr_regs.v
`timescale 1ns/1ps
`include "olr_defines.vh"
module olr_regs (
	input wire clk,
	input wire rst,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] cmd,
	input wire [15:0] wr_data,
	output reg [15:0] rd_data,
	output reg rd_valid,
	output reg wr_reject,
	output reg [11:0] otg_voltage_code,
	output reg [6:0] otg_current_code
);
	// Register images; reserved fields are zero once stored
	reg [15:0] volt_ff;
	reg [15:0] curr_ff;
	// Next values of every flip-flop
	reg [15:0] nxt_volt;
	reg [15:0] nxt_curr;
	reg [15:0] nxt_rd_data;
	reg nxt_rd_valid;
	reg nxt_wr_reject;
	reg [11:0] nxt_voltage_code;
	reg [6:0] nxt_current_code;
	// Write decode
	reg hit_any;
	reg take_volt;
	reg take_curr;
	reg refuse;
	// Outputs of the write screen
	wire volt_ok;
	wire curr_ok;
	wire [15:0] volt_clean;
	wire [15:0] curr_clean;
	// Fields of the stored images
	wire [11:0] stored_vcode;
	wire [6:0] stored_icode;
	wire stored_in_range;

	// Voltage code field of a register image
	// Reserved bits on either side are dropped here
	function [11:0] volt_field;
		input [15:0] word;
		begin
			volt_field = word[`OLR_VOLT_MSB:`OLR_VOLT_LSB];
		end
	endfunction

	// Current code field of a register image
	// Reserved bits on either side are dropped here
	function [6:0] curr_field;
		input [15:0] word;
		begin
			curr_field = word[`OLR_CURR_MSB:`OLR_CURR_LSB];
		end
	endfunction

	// Inclusive window of 3 V to 24 V in 8 mV codes
	// Both ends are legal settings, so compare inclusively
	function code_in_range;
		input [11:0] code;
		begin
			code_in_range = (code >= `OLR_VOLT_MIN_CODE) && (code <= `OLR_VOLT_MAX_CODE);
		end
	endfunction

	// Pins a code to the nearer window edge
	// Cheaper than a subtractor; only three comparisons
	function [11:0] clamp_code;
		input [11:0] code;
		begin
			if (code_in_range(code))
				clamp_code = code;
			else if (code < `OLR_VOLT_MIN_CODE)
				clamp_code = `OLR_VOLT_MIN_CODE;
			else
				clamp_code = `OLR_VOLT_MAX_CODE;
		end
	endfunction

	// Image selected by a command code; other codes read zero
	// Reads of codes owned by neighbouring registers still get rd_valid here, with zero data
	function [15:0] read_word;
		input [7:0] code;
		input [15:0] volt_word;
		input [15:0] curr_word;
		begin
			case (code)
				`OLR_CMD_VOLT: read_word = volt_word;
				`OLR_CMD_CURR: read_word = curr_word;
				default: read_word = `OLR_ZERO16;
			endcase
		end
	endfunction

	// True for the two command codes this block owns
	// Used by write decode only; read_word decodes the same two codes itself
	function cmd_is_limit;
		input [7:0] code;
		begin
			cmd_is_limit = (code == `OLR_CMD_VOLT) || (code == `OLR_CMD_CURR);
		end
	endfunction

	// Range and reserved-bit screening of the write word
	olr_write_check u_chk (
		.cmd(cmd),
		.data(wr_data),
		.volt_ok(volt_ok),
		.curr_ok(curr_ok),
		.volt_clean(volt_clean),
		.curr_clean(curr_clean)
	);

	// Codes that drive the applied limits
	assign stored_vcode = volt_field(volt_ff);
	assign stored_icode = curr_field(curr_ff);
	// Entry check keeps the store in range; clamp guards a corrupted store
	assign stored_in_range = code_in_range(stored_vcode);

	// Writes to codes owned elsewhere are neither taken nor refused
	// Refusal needs an owned code that failed its screen
	always @*
	begin
		hit_any = cmd_is_limit(cmd);
		take_volt = wr_en && volt_ok;
		take_curr = wr_en && curr_ok;
		refuse = wr_en && hit_any && !take_volt && !take_curr;
	end

	// Voltage image: a refused write leaves it untouched
	// Only screened, cleaned words are stored
	always @*
	begin
		if (take_volt)
		begin
			nxt_volt = volt_clean;
		end
		else
		begin
			nxt_volt = volt_ff;
		end
	end

	// Current image: a refused write leaves it untouched
	// Only screened, cleaned words are stored
	always @*
	begin
		if (take_curr)
		begin
			nxt_curr = curr_clean;
		end
		else
		begin
			nxt_curr = curr_ff;
		end
	end

	// One-cycle flag so the host can tell a refused write
	// No sticky status: the host must watch the pulse
	always @*
	begin
		if (refuse)
		begin
			nxt_wr_reject = 1'h1;
		end
		else
		begin
			nxt_wr_reject = 1'h0;
		end
	end

	// A read in the same cycle as a write sees the older image
	// Read data is held so the host may fetch it late
	always @*
	begin
		nxt_rd_valid = rd_en;
		if (rd_en)
		begin
			nxt_rd_data = read_word(cmd, volt_ff, curr_ff);
		end
		else
		begin
			nxt_rd_data = rd_data;
		end
	end

	// Applied limits trail the images by one cycle
	// Registered so the regulator never sees a decode glitch
	always @*
	begin
		if (stored_in_range)
		begin
			nxt_voltage_code = stored_vcode;
		end
		else
		begin
			nxt_voltage_code = clamp_code(stored_vcode);
		end
		// Current field has no window to enforce
		nxt_current_code = stored_icode;
	end

	// Power-on voltage image
	// Writes land one edge after the strobe
	always @(posedge clk)
	begin
		if (rst)
		begin
			volt_ff <= `OLR_VOLT_RESET;
		end
		else
		begin
			volt_ff <= nxt_volt;
		end
	end

	// Power-on current image
	// Writes land one edge after the strobe
	always @(posedge clk)
	begin
		if (rst)
		begin
			curr_ff <= `OLR_CURR_RESET;
		end
		else
		begin
			curr_ff <= nxt_curr;
		end
	end

	// Held until the next read
	// Cleared by reset so no stale image leaks out
	always @(posedge clk)
	begin
		if (rst)
		begin
			rd_data <= `OLR_ZERO16;
		end
		else
		begin
			rd_data <= nxt_rd_data;
		end
	end

	// One-cycle answer to each read strobe
	// Low through reset
	always @(posedge clk)
	begin
		if (rst)
		begin
			rd_valid <= 1'h0;
		end
		else
		begin
			rd_valid <= nxt_rd_valid;
		end
	end

	// One-cycle refusal pulse
	// Low through reset
	always @(posedge clk)
	begin
		if (rst)
		begin
			wr_reject <= 1'h0;
		end
		else
		begin
			wr_reject <= nxt_wr_reject;
		end
	end

	// Applied voltage code matches the reset image at once
	// so the regulator starts from a legal setting
	always @(posedge clk)
	begin
		if (rst)
		begin
			otg_voltage_code <= `OLR_VOLT_RESET_CODE;
		end
		else
		begin
			otg_voltage_code <= nxt_voltage_code;
		end
	end

	// Applied current code matches the reset image at once
	// so the limit is valid from the first cycle
	always @(posedge clk)
	begin
		if (rst)
		begin
			otg_current_code <= `OLR_CURR_RESET_CODE;
		end
		else
		begin
			otg_current_code <= nxt_current_code;
		end
	end
endmodule // olr_regs

// file: olr_write_check.v
`timescale 1ns/1ps
`include "olr_defines.vh"
module olr_write_check (
	input wire [7:0] cmd,
	input wire [15:0] data,
	output wire volt_ok,
	output wire curr_ok,
	output wire [15:0] volt_clean,
	output wire [15:0] curr_clean
);
	wire [11:0] code;
	assign code = data[`OLR_VOLT_MSB:`OLR_VOLT_LSB];
	// Range in codes: 3000/8 = 375, 24000/8 = 3000
	assign volt_ok = (cmd == `OLR_CMD_VOLT) && ((data & `OLR_VOLT_RSVD_HI) == `OLR_ZERO16)
		&& (code >= `OLR_VOLT_MIN_CODE) && (code <= `OLR_VOLT_MAX_CODE);
	assign curr_ok = (cmd == `OLR_CMD_CURR) && ((data & `OLR_CURR_RSVD_HI) == `OLR_ZERO16);
	assign volt_clean = {2'h0, code, 2'h0};
	assign curr_clean = {1'h0, data[`OLR_CURR_MSB:`OLR_CURR_LSB], 8'h00};
endmodule // olr_write_check

// file: otg_output_limit_registers_tb.sv
`timescale 1ns/1ps
module otg_output_limit_registers_tb;
reg clk = 1'h0;
reg rst = 1'h1;
integer num_errors = 0;
integer comparisons = 0;
wire wr_en;
wire rd_en;
wire rd_valid;
wire wr_reject;
wire [7:0] cmd;
wire [15:0] wr_data;
wire [15:0] rd_data;
wire [11:0] vc;
wire [6:0] ic;
initial
begin
	forever #25 clk = ~clk;
end
olr_host host (
	.clk(clk),
	.wr_en(wr_en),
	.rd_en(rd_en),
	.cmd(cmd),
	.wr_data(wr_data)
);
olr_regs dut (
	.clk(clk),
	.rst(rst),
	.wr_en(wr_en),
	.rd_en(rd_en),
	.cmd(cmd),
	.wr_data(wr_data),
	.rd_data(rd_data),
	.rd_valid(rd_valid),
	.wr_reject(wr_reject),
	.otg_voltage_code(vc),
	.otg_current_code(ic)
);
task chk(input [15:0] got, input [15:0] exp);
	begin
		comparisons = comparisons + 1;
		if (got !== exp)
		begin
			num_errors = num_errors + 1;
			$display("Error %0t got %h want %h", $time, got, exp);
		end
	end
endtask
// Write then read back; the read also lets the limit outputs settle
task step(input [7:0] c, input [15:0] d, input r, input [15:0] e);
	begin
		host.wr(c, d);
		#1 chk({15'h0000, wr_reject}, {15'h0000, r});
		host.rd(c);
		#1 chk(rd_data, e);
		chk({15'h0000, rd_valid}, 16'h0001);
		$display("test done %h %h", c, d);
	end
endtask
task finish_test;
	begin
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
endtask
initial
begin
	#60000;
	num_errors = num_errors + 1;
	finish_test;
end
initial
begin
	repeat (3) @(posedge clk);
	rst <= 1'h0;
	step(8'h3D, 16'h0000, 1'h0, 16'h0000);
	step(8'h3B, 16'hC000, 1'h1, 16'h09C4);
	step(8'h3C, 16'h8100, 1'h1, 16'h3C00);
	step(8'h3B, 16'h2EE3, 1'h0, 16'h2EE0);
	chk({4'h0, vc}, 16'h0BB8);
	step(8'h3B, 16'h2EE4, 1'h1, 16'h2EE0);
	step(8'h3B, 16'h05D8, 1'h1, 16'h2EE0);
	step(8'h3B, 16'h05DC, 1'h0, 16'h05DC);
	step(8'h3C, 16'h7FFF, 1'h0, 16'h7F00);
	chk({9'h000, ic}, 16'h007F);
	@(posedge clk);
	rst <= 1'h1;
	repeat (3) @(posedge clk);
	rst <= 1'h0;
	chk({4'h0, vc}, 16'h0271);
	chk({9'h000, ic}, 16'h003C);
	step(8'h3B, 16'hC000, 1'h1, 16'h09C4);
	step(8'h3C, 16'h8000, 1'h1, 16'h3C00);
	finish_test;
end
endmodule // otg_output_limit_registers_tb
